// ### include/afc_defines.svh
// Offsets, field positions, reset values and timing counts of the flow-control block
// What this block does
// - Option clear: abort or restart discards running conversion
// - Option clear: early restart flags error, sets abort
// - Option set: abort or restart still stores result
// - Option set: restart during last conversion, no error
// - Option set: restart before list end flags error
// - Mode bit: zero restart mode, one trigger mode
// - Access config: 01 internal, 10 bus, 11 both
// - Access config resets to 00, no path enabled
// - Config bits writable only disabled or unlocked
`ifndef AFC_DEFINES_SVH
`define AFC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define AFC_ADDR_CTRL     8'h00
`define AFC_ADDR_FLOW     8'h04
`define AFC_ADDR_STATUS   8'h08
`define AFC_ADDR_MASK     8'h0c
`define AFC_ADDR_RESULT   8'h10
`define AFC_ADDR_INFO     8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define AFC_CTRL_EN       15
`define AFC_CTRL_ACC_HI   11
`define AFC_CTRL_ACC_LO   10
`define AFC_CTRL_STORE    9
`define AFC_CTRL_MODE     8
`define AFC_CTRL_UNLOCK   5
`define AFC_ACC_RESET     2'b00
`define AFC_ACC_INT_BIT   0
`define AFC_ACC_BUS_BIT   1
`define AFC_MODE_RESTART  1'b0
`define AFC_MODE_TRIGGER  1'b1

// ----------------------------------------------------------------
// Flow-control register fields
// ----------------------------------------------------------------
`define AFC_FLOW_SEQUENCE_ABORT_REQUEST     3
`define AFC_FLOW_TRIGGER_REQUEST     2
`define AFC_FLOW_RESTART_REQUEST     1
`define AFC_FLOW_LIST_LOAD_OK     0

// ----------------------------------------------------------------
// Status and mask fields, info fields
// ----------------------------------------------------------------
`define AFC_ST_ERR        0
`define AFC_ST_CONV       1
`define AFC_ST_EOL        2
`define AFC_ST_W          3
`define AFC_INFO_ABORT    4
`define AFC_RES_W         10

// ----------------------------------------------------------------
// Timing and list length
// ----------------------------------------------------------------
`define AFC_CONV_CYCLES   8'd14
`define AFC_LAST_IDX      2'd3

`endif

// ### include/afc_pkg.sv
// Types of the flow-control block
package afc_pkg;

   typedef enum logic [1:0] {
      AFC_IDLE = 2'b00,
      AFC_CONV = 2'b01,
      AFC_WAIT = 2'b11
   } afc_fsm_t;

   typedef struct packed {
      logic       running;
      logic [7:0] cnt;
      logic       finish;
      logic [9:0] sample;
   } afc_tmr_t;

   typedef struct packed {
      afc_fsm_t    fsm;
      logic [1:0]  idx;
      logic        list_done;
      logic        enable;
      logic [1:0]  acc;
      logic        store_sel;
      logic        mode;
      logic        unlock;
      logic        sequence_abort_request;
      logic        trigger_request;
      logic        restart_request;
      logic        list_load_ok;
      logic [2:0]  status;
      logic [2:0]  mask;
      logic [9:0]  result;
      logic [1:0]  info_idx;
      logic        info_abort;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic        busy;
   } afc_top_t;

endpackage

// ### include/afc_conv_if.sv
// Link between the flow controller and its conversion timer
`timescale 1ns/100ps
interface afc_conv_if;
   logic       start;
   logic       stop;
   logic       finish;
   logic [9:0] sample;

   modport ctrl  (output start, output stop, input finish, input sample);
   modport timer (input start, input stop, output finish, output sample);
endinterface

// ### design/afc_conv_timer.sv
// Conversion timer: counts one conversion and captures its sample
`timescale 1ns/100ps
`include "afc_defines.svh"
module afc_conv_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [9:0]  sample_in,
   afc_conv_if.timer        cv
);

   afc_pkg::afc_tmr_t r;
   afc_pkg::afc_tmr_t next_r;

   always_comb begin
      next_r        = r;
      next_r.finish = 1'b0;
      if (cv.start) begin
         // A new start restarts the count even if one is running
         next_r.running = 1'b1;
         next_r.cnt     = `AFC_CONV_CYCLES;
      end else if (cv.stop) begin
         next_r.running = 1'b0;
      end else if (r.running) begin
         if (r.cnt == 8'h01) begin
            next_r.running = 1'b0;
            next_r.finish  = 1'b1;
            next_r.sample  = sample_in;
         end else begin
            next_r.cnt = r.cnt - 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign cv.finish = r.finish;
   assign cv.sample = r.sample;

endmodule

// ### design/afc_top.sv
// Flow-control block: APB registers, request arbitration and conversion sequencing
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
`include "afc_defines.svh"
module afc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   input  wire logic        special_mode,
   input  wire logic        int_sequence_abort,
   input  wire logic        int_restart,
   input  wire logic        int_trigger,
   input  wire logic        int_load_ok,
   input  wire logic [9:0]  sample_in,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             conv_busy
);

   afc_pkg::afc_top_t r;
   afc_pkg::afc_top_t next_r;

   afc_conv_if cv ();

   logic        conv_start;
   logic        conv_stop;
   logic        ev_err;
   logic        ev_conv;
   logic        ev_eol;
   logic        clr_sequence_abort_request;
   logic        clr_restart_request;
   logic        clr_trigger_request;
   logic        clr_list_load_ok;
   logic        set_sequence_abort_request;
   logic        unfinished;
   logic        last_conv;
   logic        bus_wr;
   logic        cfg_wr_ok;
   logic [31:0] wmask;
   logic [31:0] ctrl_word;
   logic [3:0]  flow_set;
   logic [3:0]  int_set;

   // ----------------------------------------------------------------
   // Conversion timer
   // ----------------------------------------------------------------
   afc_conv_timer u_timer (
      .pclk      (pclk),
      .presetn   (presetn),
      .sample_in (sample_in),
      .cv        (cv.timer)
   );

   assign cv.start = conv_start;
   assign cv.stop  = conv_stop;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   function automatic logic [31:0] read_mux(input afc_pkg::afc_top_t s, input logic [7:0] addr);
      read_mux = 32'h0000_0000;
      unique case (addr)
         `AFC_ADDR_CTRL: begin
            read_mux[`AFC_CTRL_EN]                      = s.enable;
            read_mux[`AFC_CTRL_ACC_HI:`AFC_CTRL_ACC_LO] = s.acc;
            read_mux[`AFC_CTRL_STORE]                   = s.store_sel;
            read_mux[`AFC_CTRL_MODE]                    = s.mode;
            read_mux[`AFC_CTRL_UNLOCK]                  = s.unlock;
         end
         `AFC_ADDR_FLOW: begin
            read_mux[`AFC_FLOW_SEQUENCE_ABORT_REQUEST] = s.sequence_abort_request;
            read_mux[`AFC_FLOW_TRIGGER_REQUEST] = s.trigger_request;
            read_mux[`AFC_FLOW_RESTART_REQUEST] = s.restart_request;
            read_mux[`AFC_FLOW_LIST_LOAD_OK] = s.list_load_ok;
         end
         `AFC_ADDR_STATUS: begin
            read_mux[`AFC_ST_W-1:0] = s.status;
         end
         `AFC_ADDR_MASK: begin
            read_mux[`AFC_ST_W-1:0] = s.mask;
         end
         `AFC_ADDR_RESULT: begin
            read_mux[`AFC_RES_W-1:0] = s.result;
         end
         `AFC_ADDR_INFO: begin
            read_mux[1:0]             = s.info_idx;
            read_mux[`AFC_INFO_ABORT] = s.info_abort;
         end
         default: begin
            read_mux = 32'h0000_0000;
         end
      endcase
   endfunction

   function automatic logic addr_hit(input logic [7:0] addr);
      addr_hit = (addr == `AFC_ADDR_CTRL) || (addr == `AFC_ADDR_FLOW) ||
                 (addr == `AFC_ADDR_STATUS) || (addr == `AFC_ADDR_MASK) ||
                 (addr == `AFC_ADDR_RESULT) || (addr == `AFC_ADDR_INFO);
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_r     = r;
      conv_start = 1'b0;
      conv_stop  = 1'b0;
      ev_err     = 1'b0;
      ev_conv    = 1'b0;
      ev_eol     = 1'b0;
      clr_sequence_abort_request   = 1'b0;
      clr_restart_request   = 1'b0;
      clr_trigger_request   = 1'b0;
      clr_list_load_ok   = 1'b0;
      set_sequence_abort_request   = 1'b0;
      flow_set   = 4'h0;
      int_set    = 4'h0;
      wmask      = lane_mask(pstrb);
      ctrl_word  = (read_mux(r, `AFC_ADDR_CTRL) & ~wmask) | (pwdata & wmask);
      unfinished = (r.fsm == afc_pkg::AFC_CONV) || ((r.fsm == afc_pkg::AFC_WAIT) && !r.list_done);
      last_conv  = (r.fsm == afc_pkg::AFC_CONV) && (r.idx == `AFC_LAST_IDX);

      // APB: answer one cycle into the access phase
      bus_wr      = psel && penable && r.pready && pwrite;
      cfg_wr_ok   = !r.enable || r.unlock;
      next_r.pready  = psel && penable && !r.pready;
      next_r.pslverr = psel && penable && !r.pready && !addr_hit(paddr);
      next_r.prdata  = (psel && penable && !r.pready && !pwrite) ? read_mux(r, paddr) : 32'h0000_0000;

      // Control register
      if (bus_wr && (paddr == `AFC_ADDR_CTRL)) begin
         next_r.enable = ctrl_word[`AFC_CTRL_EN];
         if (cfg_wr_ok) begin
            next_r.acc       = ctrl_word[`AFC_CTRL_ACC_HI:`AFC_CTRL_ACC_LO];
            next_r.store_sel = ctrl_word[`AFC_CTRL_STORE];
            next_r.mode      = ctrl_word[`AFC_CTRL_MODE];
         end
         if (special_mode) begin
            next_r.unlock = ctrl_word[`AFC_CTRL_UNLOCK];
         end
      end
      if (!special_mode) begin
         next_r.unlock = 1'b0;
      end

      // Request sources, each gated by its access path
      if (bus_wr && (paddr == `AFC_ADDR_FLOW) && r.acc[`AFC_ACC_BUS_BIT]) begin
         flow_set = pwdata[3:0] & {4{pstrb[0]}};
      end
      if (r.acc[`AFC_ACC_INT_BIT]) begin
         int_set = {int_sequence_abort, int_trigger, int_restart, int_load_ok};
      end

      // Sequencer
      if (!r.enable) begin
         // Disabling drops the running conversion and the abort, restart and trigger requests
         next_r.fsm       = afc_pkg::AFC_IDLE;
         next_r.list_done = 1'b0;
         conv_stop        = (r.fsm == afc_pkg::AFC_CONV);
         clr_sequence_abort_request         = 1'b1;
         clr_restart_request         = 1'b1;
         clr_trigger_request         = 1'b1;
      end else if (r.sequence_abort_request) begin
         if (r.fsm == afc_pkg::AFC_CONV) begin
            conv_stop = 1'b1;
            ev_conv   = r.store_sel;
         end
         next_r.fsm       = afc_pkg::AFC_IDLE;
         next_r.list_done = 1'b0;
         clr_sequence_abort_request         = 1'b1;
      end else if (r.restart_request) begin
         if (!r.store_sel && unfinished) begin
            // Abort first; the restart stays pending behind it
            ev_err     = 1'b1;
            set_sequence_abort_request   = 1'b1;
            conv_stop  = (r.fsm == afc_pkg::AFC_CONV);
            next_r.fsm = afc_pkg::AFC_IDLE;
         end else begin
            if (r.fsm == afc_pkg::AFC_CONV) begin
               conv_stop = 1'b1;
               ev_conv   = r.store_sel;
            end
            ev_err           = r.store_sel && unfinished && !last_conv;
            clr_restart_request         = 1'b1;
            clr_list_load_ok         = 1'b1;
            next_r.idx       = 2'b00;
            next_r.list_done = 1'b0;
            if (r.mode == `AFC_MODE_RESTART) begin
               next_r.fsm = afc_pkg::AFC_CONV;
               conv_start = 1'b1;
            end else begin
               next_r.fsm = afc_pkg::AFC_WAIT;
            end
         end
      end else begin
         unique case (r.fsm)
            afc_pkg::AFC_IDLE: begin
               clr_trigger_request = 1'b1;
            end
            afc_pkg::AFC_WAIT: begin
               if (r.trigger_request) begin
                  clr_trigger_request         = 1'b1;
                  next_r.fsm       = afc_pkg::AFC_CONV;
                  next_r.list_done = 1'b0;
                  conv_start       = 1'b1;
               end
            end
            afc_pkg::AFC_CONV: begin
               clr_trigger_request = 1'b1;
               if (cv.finish) begin
                  ev_conv = 1'b1;
                  if (r.idx == `AFC_LAST_IDX) begin
                     ev_eol           = 1'b1;
                     next_r.idx       = 2'b00;
                     next_r.list_done = 1'b1;
                     next_r.fsm       = (r.mode == `AFC_MODE_TRIGGER) ? afc_pkg::AFC_WAIT : afc_pkg::AFC_IDLE;
                  end else begin
                     next_r.idx = r.idx + 2'b01;
                     if (r.mode == `AFC_MODE_RESTART) begin
                        conv_start = 1'b1;
                     end else begin
                        next_r.fsm = afc_pkg::AFC_WAIT;
                     end
                  end
               end
            end
            default: begin
               next_r.fsm = afc_pkg::AFC_IDLE;
            end
         endcase
      end

      // Result storage
      if (ev_conv) begin
         next_r.result     = cv.finish ? cv.sample : sample_in;
         next_r.info_idx   = r.idx;
         next_r.info_abort = !cv.finish;
      end

      // Flow bits: hardware clears first, new requests win
      next_r.sequence_abort_request = (r.sequence_abort_request & ~clr_sequence_abort_request) | set_sequence_abort_request | flow_set[`AFC_FLOW_SEQUENCE_ABORT_REQUEST] | int_set[`AFC_FLOW_SEQUENCE_ABORT_REQUEST];
      next_r.restart_request = (r.restart_request & ~clr_restart_request) | flow_set[`AFC_FLOW_RESTART_REQUEST] | int_set[`AFC_FLOW_RESTART_REQUEST];
      next_r.trigger_request = (r.trigger_request & ~clr_trigger_request) | flow_set[`AFC_FLOW_TRIGGER_REQUEST] | int_set[`AFC_FLOW_TRIGGER_REQUEST];
      next_r.list_load_ok = (r.list_load_ok & ~clr_list_load_ok) | flow_set[`AFC_FLOW_LIST_LOAD_OK] | int_set[`AFC_FLOW_LIST_LOAD_OK];

      // Status: write one to clear, events win
      if (bus_wr && (paddr == `AFC_ADDR_STATUS)) begin
         next_r.status = r.status & ~(pwdata[`AFC_ST_W-1:0] & {`AFC_ST_W{pstrb[0]}});
      end
      if (bus_wr && (paddr == `AFC_ADDR_MASK) && pstrb[0]) begin
         next_r.mask = pwdata[`AFC_ST_W-1:0];
      end
      next_r.status[`AFC_ST_ERR]  = next_r.status[`AFC_ST_ERR] | ev_err;
      next_r.status[`AFC_ST_CONV] = next_r.status[`AFC_ST_CONV] | ev_conv;
      next_r.status[`AFC_ST_EOL]  = next_r.status[`AFC_ST_EOL] | ev_eol;

      next_r.irq  = |(next_r.status & next_r.mask);
      next_r.busy = (next_r.fsm == afc_pkg::AFC_CONV);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r     <= '0;
         r.acc <= `AFC_ACC_RESET;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata    = r.prdata;
   assign pready    = r.pready;
   assign pslverr   = r.pslverr;
   assign irq       = r.irq;
   assign conv_busy = r.busy;

endmodule

// ### verification/afc_int_model.sv
// Internal-interface requester standing in for on-chip trigger logic
`timescale 1ns/100ps
module afc_int_model (
   input  wire logic  pclk,
   output logic       int_sequence_abort,
   output logic       int_restart,
   output logic       int_trigger,
   output logic       int_load_ok,
   output logic [9:0] sample_in
);
   logic [3:0] req;
   initial req = 4'h0;
   initial sample_in = 10'h155;
   // Sample moves every cycle so a stale capture cannot pass
   always @(posedge pclk) sample_in <= sample_in + 10'h00b;
   assign {int_sequence_abort, int_trigger, int_restart, int_load_ok} = req;
   // One-cycle request pulse, bits ordered as in the flow register
   task fire(input logic [3:0] bits);
      @(posedge pclk);
      req <= bits;
      @(posedge pclk);
      req <= 4'h0;
   endtask
endmodule

// ### verification/afc_top_chk.sv
// Port-level assertions of the flow-control block
`timescale 1ns/100ps
module afc_top_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        conv_busy
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held over one cycle");
   a_ready_latency: assert property (psel && $rose(penable) |=> pready)
      else $error("pready late after access start");
   a_no_stray_ready: assert property (!psel |=> !pready)
      else $error("pready without a transfer");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_unmapped_err: assert property (psel && $rose(penable) && paddr > 8'h14 |=> pslverr)
      else $error("unmapped access not flagged");
   a_reset_quiet: assert property (!$past(presetn) |-> !pready && !irq && !conv_busy)
      else $error("outputs active right after reset");
   a_flow_reserved: assert property (pready && !pwrite && paddr == 8'h04 |-> prdata[31:4] == 28'h0)
      else $error("flow register reserved bits set");
endmodule
bind afc_top afc_top_chk afc_top_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
   .conv_busy(conv_busy));

// ### verification/testbench.sv
// Self-checking bench of the flow-control block
`timescale 1ns/100ps
`include "afc_defines.svh"
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, special_mode;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic        ia, ir, it, il, pready, pslverr, irq, conv_busy, perr;
   logic [9:0]  smp;
   int          err_total, n_checks, cyc;

   always #25 pclk = ~pclk;

   afc_top afc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .special_mode(special_mode),
      .int_sequence_abort(ia), .int_restart(ir), .int_trigger(it), .int_load_ok(il),
      .sample_in(smp), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .conv_busy(conv_busy));
   afc_int_model afc_int_model_i (.pclk(pclk), .int_sequence_abort(ia), .int_restart(ir),
      .int_trigger(it), .int_load_ok(il), .sample_in(smp));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Request stands until the edge that samples pready high
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task idle(input int n);
      repeat (n) @(negedge pclk);
   endtask

   // Disable, then enable with new access, store and mode settings
   task cfg(input logic [1:0] a, input logic s, input logic m);
      wr(`AFC_ADDR_CTRL, 32'h0);
      wr(`AFC_ADDR_CTRL, {16'h0, 1'b1, 3'b0, a, s, m, 8'h0});
   endtask

   task end_sim;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset;
      rdchk(`AFC_ADDR_CTRL, 32'h0);
      chk(perr, 32'h0);
      wr(`AFC_ADDR_CTRL, 32'h8000);
      wr(`AFC_ADDR_FLOW, 32'h2);
      afc_int_model_i.fire(4'h2);
      idle(5);
      chk(conv_busy, 32'h0);
      rdchk(`AFC_ADDR_FLOW, 32'h0);
   endtask

   task t_access;
      logic [1:0] a;
      for (int k = 1; k < 4; k++) begin
         a = k[1:0];
         cfg(a, 1'b0, 1'b0);
         afc_int_model_i.fire(4'h2);
         idle(5);
         chk(conv_busy, {31'h0, a[0]});
         cfg(a, 1'b0, 1'b0);
         wr(`AFC_ADDR_FLOW, 32'h2);
         idle(5);
         chk(conv_busy, {31'h0, a[1]});
      end
   endtask

   task t_store0;
      cfg(2'b11, 1'b0, 1'b0);
      wr(`AFC_ADDR_STATUS, 32'h7);
      wr(`AFC_ADDR_FLOW, 32'h2);
      idle(5);
      wr(`AFC_ADDR_FLOW, 32'h2);
      idle(3);
      rdchk(`AFC_ADDR_STATUS, 32'h1);
      chk(irq, 32'h0);
      wr(`AFC_ADDR_MASK, 32'h1);
      idle(2);
      chk(irq, 32'h1);
      wr(`AFC_ADDR_STATUS, 32'h1);
      idle(2);
      chk(irq, 32'h0);
   endtask

   task t_store1;
      cfg(2'b11, 1'b1, 1'b0);
      wr(`AFC_ADDR_STATUS, 32'h7);
      wr(`AFC_ADDR_FLOW, 32'h2);
      idle(5);
      wr(`AFC_ADDR_FLOW, 32'h8);
      idle(3);
      rdchk(`AFC_ADDR_STATUS, 32'h2);
      rdchk(`AFC_ADDR_INFO, 32'h10);
      wr(`AFC_ADDR_STATUS, 32'h7);
      wr(`AFC_ADDR_FLOW, 32'h2);
      idle(5);
      wr(`AFC_ADDR_FLOW, 32'h2);
      idle(3);
      rdchk(`AFC_ADDR_STATUS, 32'h3);
      cfg(2'b11, 1'b1, 1'b0);
      wr(`AFC_ADDR_STATUS, 32'h7);
      wr(`AFC_ADDR_FLOW, 32'h2);
      idle(48);
      wr(`AFC_ADDR_FLOW, 32'h2);
      idle(2);
      apb(1'b0, `AFC_ADDR_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h0);
   endtask

   task t_mode;
      cfg(2'b11, 1'b0, 1'b1);
      wr(`AFC_ADDR_FLOW, 32'h2);
      idle(20);
      chk(conv_busy, 32'h0);
      wr(`AFC_ADDR_FLOW, 32'h4);
      idle(5);
      chk(conv_busy, 32'h1);
   endtask

   task t_lock;
      cfg(2'b10, 1'b0, 1'b0);
      wr(`AFC_ADDR_CTRL, 32'h8f00);
      rdchk(`AFC_ADDR_CTRL, 32'h8800);
      special_mode <= 1'b1;
      wr(`AFC_ADDR_CTRL, 32'h8820);
      wr(`AFC_ADDR_CTRL, 32'h8f20);
      rdchk(`AFC_ADDR_CTRL, 32'h8f20);
      special_mode <= 1'b0;
      idle(2);
      rdchk(`AFC_ADDR_CTRL, 32'h8f00);
      // Lane 0 only: the enable bit in lane 1 must keep its value
      pstrb <= 4'h1;
      wr(`AFC_ADDR_CTRL, 32'h0);
      pstrb <= 4'hf;
      rdchk(`AFC_ADDR_CTRL, 32'h8f00);
      wr(8'h20, 32'hffff);
      rdchk(8'h20, 32'h0);
      chk(perr, 32'h1);
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         end_sim;
      end
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      special_mode = 1'b0;
      err_total = 0;
      n_checks = 0;
      cyc = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_access;
      t_store0;
      t_store1;
      t_mode;
      t_lock;
      end_sim;
   end
endmodule
